// ---- inc/spcm_pkg.sv ----
`default_nettype none

package spcm_pkg;

  // serial frame layout: one instruction byte, one data byte
  localparam int unsigned ADDR_W = 6;
  localparam logic [4:0] INSTR_LAST = 5'h07;
  localparam logic [4:0] DATA_FIRST = 5'h08;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int unsigned INSTR_RD_BIT = 7;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_GEN = 6'h00;
  localparam logic [ADDR_W-1:0] REG_CKM = 6'h01;
  localparam logic [ADDR_W-1:0] REG_IOC = 6'h14;

  // serial_port_general_control fields
  localparam int unsigned GEN_PIN_SEL_BIT = 7;
  localparam int unsigned GEN_LSB_BIT = 6;
  localparam int unsigned GEN_SRST_BIT = 5;
  localparam logic [7:0] GEN_RST = 8'h00;
  localparam logic [7:0] GEN_MASK = 8'hc0;

  // interface_clocking_select fields
  localparam int unsigned CKM_MODE_HI = 7;
  localparam int unsigned CKM_MODE_LO = 5;
  localparam int unsigned CKM_IF2_BIT = 2;
  localparam int unsigned CKM_IF3_BIT = 1;
  localparam logic [7:0] CKM_RST = 8'h00;
  localparam logic [7:0] CKM_MASK = 8'he6;

  // i/o configuration fields
  localparam int unsigned IOC_CLONE_BIT = 0;
  localparam logic [7:0] IOC_RST = 8'h00;
  localparam logic [7:0] IOC_MASK = 8'h3f;

  typedef enum logic [2:0] {
    TM_STANDARD = 3'h0,
    TM_FULL_ALT = 3'h1,
    TM_WIDE_ALT = 3'h3,
    TM_NARROW_ALT = 3'h5,
    TM_CLONE = 3'h7
  } spcm_timing_e;

endpackage : spcm_pkg

`default_nettype wire

// ---- logic/spcm_sync.sv ----
`default_nettype none

module spcm_sync #(
  parameter int unsigned WIDTH = 2
) (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // levels from the serial domain
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : spcm_sync

`default_nettype wire

// ---- logic/spcm_top.sv ----
`default_nettype none

// Overview of operation
// [R01] With the pin select bit clear (default) reads leave on the separate output pin.
// [R02] With the pin select bit set, reads turn the data input pin around and drive it.
// [R03] With the bit order bit clear (default) bytes shift most significant bit first.
// [R04] With the bit order bit set, bytes shift least significant bit first, both ways.
// [R05] Writing one to soft reset restores every register default and pulses a PLL relock.
// [R06] Soft reset clears itself at the end of its write and never reads back as one.
// [R07] The timing select field sits in bits 7:5, default 000, standard timing for all modes.
// [R08] Timing select 001 picks the alternative full-duplex timing.
// [R09] Timing select 101 picks the alternative narrow half-duplex timing.
// [R10] Timing select 111 picks the clone clocking arrangement.
// [R11] The host must not write codes 010, 100 or 110; they are flagged as undefined.
// [R12] Timing select 011 picks the alternative wide half-duplex timing.
// [R13] Clone operation needs the clone enable bit of the i/o register as well as 111.
module spcm_top (
  // system clock domain
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // serial configuration port
  input wire logic spi_sclk,
  input wire logic spi_csb_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_data_output_pin,
  output logic out_pin_oe,
  // interface clocking selection, clk_sys domain
  output logic [2:0] timing_sel,
  output logic timing_std,
  output logic full_duplex_interface_alt,
  output logic half_duplex_wide_interface_alt,
  output logic half_duplex_narrow_interface_alt,
  output logic clone_active,
  output logic timing_code_unused,
  output logic iface2_clkout_en,
  output logic iface3_clkout_inv,
  output logic [7:0] io_config,
  // clock generator
  output logic pll_relock
);

  // serial domain state
  logic [4:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] byte_d;
  logic rd_q;
  logic [spcm_pkg::ADDR_W-1:0] addr_q;
  logic [7:0] rd_data_q;
  logic [7:0] gen_q;
  logic [7:0] ckm_q;
  logic [7:0] ioc_q;
  logic cfg_tgl_q;
  logic srst_tgl_q;
  logic obit_q;
  logic drive_q;
  logic serial_pin_select;
  logic lsb_first;
  logic wr_done;
  logic srst_hit;

  // system domain state
  logic [1:0] tgl_s;
  logic [1:0] tgl_p_q;
  logic cfg_evt;
  logic srst_evt;
  logic [2:0] mode_d;
  logic std_d;
  logic full_alt_d;
  logic wide_alt_d;
  logic narrow_alt_d;
  logic clone_sel_d;
  logic unused_d;

  function automatic logic [7:0] reg_read(input logic [spcm_pkg::ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      spcm_pkg::REG_GEN: v = gen_q & spcm_pkg::GEN_MASK;
      spcm_pkg::REG_CKM: v = ckm_q & spcm_pkg::CKM_MASK;
      spcm_pkg::REG_IOC: v = ioc_q & spcm_pkg::IOC_MASK;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  assign serial_pin_select = gen_q[spcm_pkg::GEN_PIN_SEL_BIT];
  assign lsb_first = gen_q[spcm_pkg::GEN_LSB_BIT];

  // the byte as it stands once the current bit is taken in
  always_comb begin
    if (lsb_first) begin
      byte_d = {sdio_in, shift_q[7:1]}; // [R04]
    end else begin
      byte_d = {shift_q[6:0], sdio_in}; // [R03]
    end
  end

  assign wr_done = (bit_cnt_q == spcm_pkg::FRAME_LAST) && !rd_q;
  assign srst_hit = wr_done && (addr_q == spcm_pkg::REG_GEN) &&
    byte_d[spcm_pkg::GEN_SRST_BIT];

  // chip select high ends the frame even if the serial clock has already stopped
  always_ff @(posedge spi_sclk or posedge spi_csb_n or posedge sys_rst) begin
    if (sys_rst || spi_csb_n) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != spcm_pkg::FRAME_BITS) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge spi_sclk or posedge spi_csb_n or posedge sys_rst) begin
    if (sys_rst || spi_csb_n) begin
      shift_q <= 8'h00;
    end else begin
      shift_q <= byte_d;
    end
  end

  // instruction byte: read flag and address, read data fetched at once
  always_ff @(posedge spi_sclk or posedge spi_csb_n or posedge sys_rst) begin
    if (sys_rst || spi_csb_n) begin
      rd_q <= 1'b0;
      addr_q <= 6'h00;
      rd_data_q <= 8'h00;
    end else if (bit_cnt_q == spcm_pkg::INSTR_LAST) begin
      rd_q <= byte_d[spcm_pkg::INSTR_RD_BIT];
      addr_q <= byte_d[spcm_pkg::ADDR_W-1:0];
      rd_data_q <= reg_read(byte_d[spcm_pkg::ADDR_W-1:0]);
    end
  end

  // register bank; the soft reset bit itself is never stored
  always_ff @(posedge spi_sclk or posedge sys_rst) begin
    if (sys_rst) begin
      gen_q <= spcm_pkg::GEN_RST;
      ckm_q <= spcm_pkg::CKM_RST;
      ioc_q <= spcm_pkg::IOC_RST;
    end else if (srst_hit) begin
      gen_q <= spcm_pkg::GEN_RST; // [R05] [R06]
      ckm_q <= spcm_pkg::CKM_RST; // [R05]
      ioc_q <= spcm_pkg::IOC_RST; // [R05]
    end else if (wr_done) begin
      unique case (addr_q)
        spcm_pkg::REG_GEN: gen_q <= byte_d & spcm_pkg::GEN_MASK; // [R06]
        spcm_pkg::REG_CKM: ckm_q <= byte_d & spcm_pkg::CKM_MASK; // [R07]
        spcm_pkg::REG_IOC: ioc_q <= byte_d & spcm_pkg::IOC_MASK;
        default: ;
      endcase
    end
  end

  // events towards clk_sys; register words stay put until the next frame
  always_ff @(posedge spi_sclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_tgl_q <= 1'b0;
    end else if (wr_done) begin
      cfg_tgl_q <= ~cfg_tgl_q;
    end
  end

  always_ff @(posedge spi_sclk or posedge sys_rst) begin
    if (sys_rst) begin
      srst_tgl_q <= 1'b0;
    end else if (srst_hit) begin
      srst_tgl_q <= ~srst_tgl_q; // [R05]
    end
  end

  // read data changes on the falling edge so the host samples it on the rising one
  always_ff @(negedge spi_sclk or posedge spi_csb_n or posedge sys_rst) begin
    if (sys_rst || spi_csb_n) begin
      obit_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (rd_q && (bit_cnt_q >= spcm_pkg::DATA_FIRST) &&
                 (bit_cnt_q != spcm_pkg::FRAME_BITS)) begin
      drive_q <= 1'b1;
      if (lsb_first) begin
        obit_q <= rd_data_q[bit_cnt_q[2:0]]; // [R04]
      end else begin
        obit_q <= rd_data_q[3'h7 - bit_cnt_q[2:0]]; // [R03]
      end
    end else begin
      drive_q <= 1'b0;
    end
  end

  assign sdio_out = obit_q;
  assign serial_data_output_pin = obit_q;
  assign sdio_oe = drive_q && serial_pin_select; // [R02]
  assign out_pin_oe = drive_q && !serial_pin_select; // [R01]

  spcm_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d({srst_tgl_q, cfg_tgl_q}),
    .q(tgl_s)
  );

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tgl_p_q <= 2'h0;
    end else if (clk_en) begin
      tgl_p_q <= tgl_s;
    end
  end

  assign cfg_evt = tgl_s[0] ^ tgl_p_q[0];
  assign srst_evt = tgl_s[1] ^ tgl_p_q[1];

  // decode of the timing select field
  always_comb begin
    mode_d = ckm_q[spcm_pkg::CKM_MODE_HI:spcm_pkg::CKM_MODE_LO];
    std_d = 1'b0;
    full_alt_d = 1'b0;
    wide_alt_d = 1'b0;
    narrow_alt_d = 1'b0;
    clone_sel_d = 1'b0;
    unused_d = 1'b0;
    unique case (mode_d)
      spcm_pkg::TM_STANDARD: std_d = 1'b1; // [R07]
      spcm_pkg::TM_FULL_ALT: full_alt_d = 1'b1; // [R08]
      spcm_pkg::TM_WIDE_ALT: wide_alt_d = 1'b1; // [R12]
      spcm_pkg::TM_NARROW_ALT: narrow_alt_d = 1'b1; // [R09]
      spcm_pkg::TM_CLONE: clone_sel_d = 1'b1; // [R10]
      // codes the host is not meant to write
      default: unused_d = 1'b1; // [R11]
    endcase
  end

  // words are taken only after their toggle has crossed, so they are stable
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      timing_sel <= spcm_pkg::CKM_RST[spcm_pkg::CKM_MODE_HI:spcm_pkg::CKM_MODE_LO];
      timing_std <= 1'b1;
      full_duplex_interface_alt <= 1'b0;
      half_duplex_wide_interface_alt <= 1'b0;
      half_duplex_narrow_interface_alt <= 1'b0;
      clone_active <= 1'b0;
      timing_code_unused <= 1'b0;
      iface2_clkout_en <= 1'b0;
      iface3_clkout_inv <= 1'b0;
      io_config <= spcm_pkg::IOC_RST;
    end else if (clk_en && cfg_evt) begin
      timing_sel <= mode_d; // [R07]
      timing_std <= std_d;
      full_duplex_interface_alt <= full_alt_d;
      half_duplex_wide_interface_alt <= wide_alt_d;
      half_duplex_narrow_interface_alt <= narrow_alt_d;
      clone_active <= clone_sel_d && ioc_q[spcm_pkg::IOC_CLONE_BIT]; // [R13]
      timing_code_unused <= unused_d;
      iface2_clkout_en <= ckm_q[spcm_pkg::CKM_IF2_BIT];
      iface3_clkout_inv <= ckm_q[spcm_pkg::CKM_IF3_BIT];
      io_config <= ioc_q & spcm_pkg::IOC_MASK;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pll_relock <= 1'b0;
    end else if (clk_en) begin
      pll_relock <= srst_evt; // [R05]
    end
  end

  a_four_wire_out: assert property (@(posedge spi_sclk) disable iff (sys_rst) // [R01]
    !serial_pin_select |-> !sdio_oe)
    else $error("data pin driven in four-wire mode");

  a_three_wire_out: assert property (@(posedge spi_sclk) disable iff (sys_rst) // [R02]
    (serial_pin_select && rd_q && bit_cnt_q > spcm_pkg::DATA_FIRST &&
     bit_cnt_q != spcm_pkg::FRAME_BITS) |-> (sdio_oe && !out_pin_oe))
    else $error("three-wire read not driven on the data pin");

  a_msb_first_wr: assert property (@(posedge spi_sclk) disable iff (sys_rst) // [R03]
    (wr_done && !lsb_first && addr_q == spcm_pkg::REG_CKM) |=>
    ckm_q[7:5] == {$past(sdio_in, 8), $past(sdio_in, 7), $past(sdio_in, 6)})
    else $error("msb-first write stored in wrong order");

  a_lsb_first_wr: assert property (@(posedge spi_sclk) disable iff (sys_rst) // [R04]
    (wr_done && lsb_first && addr_q == spcm_pkg::REG_CKM) |=>
    ckm_q[7:5] == {$past(sdio_in, 1), $past(sdio_in, 2), $past(sdio_in, 3)})
    else $error("lsb-first write stored in wrong order");

  a_soft_reset_all: assert property (@(posedge spi_sclk) disable iff (sys_rst) // [R05]
    srst_hit |=> (gen_q == spcm_pkg::GEN_RST && ckm_q == spcm_pkg::CKM_RST &&
                  ioc_q == spcm_pkg::IOC_RST && srst_tgl_q != $past(srst_tgl_q)))
    else $error("soft reset did not restore defaults");

  a_soft_reset_clear: assert property (@(posedge spi_sclk) disable iff (sys_rst) // [R06]
    (rd_q && addr_q == spcm_pkg::REG_GEN && bit_cnt_q >= spcm_pkg::DATA_FIRST) |->
    !rd_data_q[spcm_pkg::GEN_SRST_BIT])
    else $error("soft reset bit read back as one");

  a_relock_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R05]
    (clk_en && srst_evt) |=> pll_relock)
    else $error("relock not pulsed after soft reset");

  a_default_std: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R07]
    timing_std == (timing_sel == 3'h0))
    else $error("standard timing flag disagrees with select");

  a_full_alt_code: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R08]
    full_duplex_interface_alt == (timing_sel == 3'h1))
    else $error("full-duplex alt flag disagrees with select");

  a_narrow_alt_code: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R09]
    half_duplex_narrow_interface_alt == (timing_sel == 3'h5))
    else $error("narrow half-duplex alt flag disagrees with select");

  a_wide_alt_code: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R12]
    half_duplex_wide_interface_alt == (timing_sel == 3'h3))
    else $error("wide half-duplex alt flag disagrees with select");

  a_clone_needs_both: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R10] [R13]
    clone_active == (timing_sel == 3'h7 && io_config[spcm_pkg::IOC_CLONE_BIT]))
    else $error("clone active without both conditions");

  a_relock_single: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R05]
    (clk_en && pll_relock) |=> !pll_relock)
    else $error("relock pulse longer than one cycle");

  a_unused_code: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R11]
    timing_code_unused == (timing_sel == 3'h2 || timing_sel == 3'h4 || timing_sel == 3'h6))
    else $error("unused code flag disagrees with select");

  a_oe_exclusive: assert property (@(posedge spi_sclk) disable iff (sys_rst) // [R01] [R02]
    !(sdio_oe && out_pin_oe))
    else $error("both data pins driven at once");

  a_instr_released: assert property (@(posedge spi_sclk) disable iff (sys_rst) // [R01] [R02]
    (bit_cnt_q < spcm_pkg::DATA_FIRST) |-> (!sdio_oe && !out_pin_oe))
    else $error("data pin driven during the instruction byte");

  a_four_wire_read: assert property (@(posedge spi_sclk) disable iff (sys_rst) // [R01]
    (!serial_pin_select && rd_q && bit_cnt_q > spcm_pkg::DATA_FIRST &&
     bit_cnt_q != spcm_pkg::FRAME_BITS) |-> (out_pin_oe && !sdio_oe))
    else $error("four-wire read not driven on the output pin");

endmodule : spcm_top

`default_nettype wire

// ---- tb/spcm_host.sv ----
`default_nettype none

module spcm_host (
  // serial lines driven by the host
  output logic spi_sclk,
  output logic spi_csb_n,
  output logic sdio_wire,
  // device side of the pins
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_data_output_pin,
  input wire logic out_pin_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic drv_q;
  logic dat_q;

  // a released pin shows the inverse of its last level, never a stale copy
  assign sdio_wire = drv_q ? dat_q : (sdio_oe ? sdio_out : ~dat_q);

  initial begin
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    drv_q = 1'b1;
    dat_q = 1'b0;
  end

  // sclk only runs inside frames
  task automatic xfer(input logic rd, input logic [5:0] addr, input logic [7:0] wd,
      input logic lsb, input logic bidir, output logic [7:0] rdat, output logic oe_ok);
    logic [15:0] frm;
    int k;
    int j;
    frm = {rd, 1'b0, addr, wd};
    rdat = 8'h00;
    oe_ok = 1'b1;
    #1.3 spi_csb_n = 1'b0;
    for (k = 0; k < 16; k++) begin
      j = k % 8;
      drv_q = !(rd && bidir && k > 7);
      if (drv_q) dat_q = frm[(k < 8 ? 8 : 0) + (lsb ? j : 7 - j)];
      #15;
      if (rd && k > 7) begin
        rdat[lsb ? j : 7 - j] = bidir ? sdio_wire : serial_data_output_pin;
        if (!(bidir ? (sdio_oe && !out_pin_oe) : (out_pin_oe && !sdio_oe))) oe_ok = 1'b0;
      end
      spi_sclk = 1'b1;
      #15 spi_sclk = 1'b0;
    end
    #15 spi_csb_n = 1'b1;
    drv_q = 1'b1;
    #30;
  endtask : xfer
endmodule : spcm_host

`default_nettype wire

// ---- tb/spcm_top_tb.sv ----
`default_nettype none

module spcm_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic spi_sclk, spi_csb_n, sdio_wire, sdio_out, sdio_oe, out_pin, out_pin_oe;
  logic [2:0] timing_sel;
  logic t_std, t_full, t_wide, t_narrow, t_clone, t_unused, if2_en, if3_inv, pll_relock;
  logic [7:0] io_config;
  logic [7:0] relocks = 8'h00;
  logic [7:0] base;
  logic lsb_m = 1'b0;
  logic bidir_m = 1'b0;
  int miscompares = 0;
  int samples_checked = 0;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
  logic [7:0] exp_f [5] = '{8'h83, 8'h43, 8'h23, 8'h13, 8'h03};

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (pll_relock === 1'b1) relocks <= relocks + 8'h01;

  spcm_host host (.spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n), .sdio_wire(sdio_wire),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_data_output_pin(out_pin),
    .out_pin_oe(out_pin_oe));

  spcm_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n), .sdio_in(sdio_wire),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_data_output_pin(out_pin),
    .out_pin_oe(out_pin_oe), .timing_sel(timing_sel), .timing_std(t_std),
    .full_duplex_interface_alt(t_full), .half_duplex_wide_interface_alt(t_wide),
    .half_duplex_narrow_interface_alt(t_narrow), .clone_active(t_clone),
    .timing_code_unused(t_unused), .iface2_clkout_en(if2_en),
    .iface3_clkout_inv(if3_inv), .io_config(io_config), .pll_relock(pll_relock));

  function automatic logic [7:0] flags();
    return {t_std, t_full, t_wide, t_narrow, t_clone, t_unused, if2_en, if3_inv};
  endfunction : flags

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    logic [7:0] r;
    logic ok;
    host.xfer(1'b0, addr, data, lsb_m, bidir_m, r, ok);
  endtask : wr

  task automatic rdchk(input logic [5:0] addr, input logic [7:0] exp);
    logic [7:0] r;
    logic ok;
    host.xfer(1'b1, addr, 8'h00, lsb_m, bidir_m, r, ok);
    check(r, exp);
    check({7'h00, ok}, 8'h01);
  endtask : rdchk

  // clk_sys side lands 3-4 edges after the frame
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask : settle

  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rdchk(spcm_pkg::REG_GEN, 8'h00);
    rdchk(spcm_pkg::REG_CKM, 8'h00);
    check(flags(), 8'h80);
    for (int i = 0; i < 5; i++) begin
      wr(spcm_pkg::REG_CKM, {codes[i], 5'h06});
      settle();
      check({5'h00, timing_sel}, {5'h00, codes[i]});
      check(flags(), exp_f[i]);
      rdchk(spcm_pkg::REG_CKM, {codes[i], 5'h06});
    end
    wr(spcm_pkg::REG_IOC, 8'hff);
    settle();
    check(io_config, 8'h3f);
    check(flags(), 8'h0b);
    rdchk(spcm_pkg::REG_IOC, 8'h3f);
    // frozen system side must hold until enabled again
    @(posedge clk_sys) clk_en <= 1'b0;
    wr(spcm_pkg::REG_CKM, 8'h20);
    repeat (20) @(posedge clk_sys);
    check(flags(), 8'h0b);
    clk_en <= 1'b1;
    settle();
    check(flags(), 8'h40);
    wr(6'h3e, 8'hff);
    rdchk(6'h3e, 8'h00);
    wr(spcm_pkg::REG_GEN, 8'h80);
    bidir_m = 1'b1;
    rdchk(spcm_pkg::REG_GEN, 8'h80);
    wr(spcm_pkg::REG_GEN, 8'hc0);
    lsb_m = 1'b1;
    rdchk(spcm_pkg::REG_GEN, 8'hc0);
    rdchk(spcm_pkg::REG_CKM, 8'h20);
    wr(spcm_pkg::REG_CKM, 8'ha2);
    settle();
    check(flags(), 8'h11);
    rdchk(spcm_pkg::REG_CKM, 8'ha2);
    base = relocks;
    wr(spcm_pkg::REG_GEN, 8'he0);
    lsb_m = 1'b0;
    bidir_m = 1'b0;
    settle();
    check(relocks - base, 8'h01);
    check(flags(), 8'h80);
    check(io_config, 8'h00);
    rdchk(spcm_pkg::REG_GEN, 8'h00);
    rdchk(spcm_pkg::REG_CKM, 8'h00);
    rdchk(spcm_pkg::REG_IOC, 8'h00);
    wrap_up();
  end
endmodule : spcm_top_tb

`default_nettype wire
